// ---- hw/pwm_timer16.sv ----
// 16-bit timer with fast and phase correct PWM, APB register slave
//
// Function
// - Fast PWM modes count BOTTOM up to TOP, then restart at BOTTOM.
// - Fast PWM non-inverting clears on match, sets at BOTTOM; inverting opposite.
// - Polarity 2 gives non-inverted PWM, polarity 3 gives inverted PWM.
// - Fast TOP is 0xFF, 0x1FF, 0x3FF, capture top or compare A.
// - Fast PWM sets overflow and the TOP source flag when count hits TOP.
// - Each channel flag sets when the count equals its compare value.
// - Fixed TOP modes mask compare writes above the selected resolution.
// - Capture top acts at once; a missed match wraps through 0xFFFF.
// - Fast PWM loads buffered compare A at TOP, with clear and overflow.
// - A waveform reaches its pin only while the direction bit is set.
// - Fast PWM compare 0 gives a one-tick spike; compare TOP a constant.
// - Polarity 1 toggles output A on match, fast PWM only mode 15.
// - Timer tick is the clock divided by 1, 8, 64, 256 or 1024.
// - Dual-slope counts up to TOP then down; TOP chosen by mode.
// - Dual-slope count holds TOP for exactly one tick before descending.
// - Dual-slope non-inverting clears on up match, sets on down match.
// - Dual-slope sets overflow each time the count reaches BOTTOM.
// - Dual-slope loads buffers at TOP and sets TOP source flag then.
// - Dual-slope compare BOTTOM gives constant low, TOP constant high.
// - Mode 11 with polarity 1 toggles output A on each match.
`timescale 1ns/100ps
`default_nettype none

module pwm_timer16
  import pwm_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] waveform_output,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe
);

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    bus_state_t bus;
    logic [31:0] rdata;
    logic slverr;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] cnt;
    logic up;
    logic [9:0] pre;
    logic [1:0][15:0] buf_v;
    logic [1:0][15:0] act_v;
    logic [15:0] captop;
    logic [3:0] flags;
    logic [1:0] wave;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic [3:0] mode;
  logic [1:0][1:0] pol;
  logic [2:0] presc;
  logic fast_mode;
  logic dual_mode;
  logic fixed_top;
  logic [15:0] top_v;
  logic [15:0] res_mask;
  logic [9:0] div_max;
  logic tick;
  logic at_top;
  logic [1:0] match;
  logic wr_en;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic [3:0] fset;
  logic [3:0] fclr;

  assign mode = state_q.ctrl[MODE_LSB +: 4];
  assign pol[0] = state_q.ctrl[POLA_LSB +: 2];
  assign pol[1] = state_q.ctrl[POLB_LSB +: 2];
  assign presc = state_q.ctrl[PRESC_LSB +: 3];

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // single-slope mode set
  assign fast_mode = (mode == MODE_FAST8) || (mode == MODE_FAST9) ||
                     (mode == MODE_FAST10) || (mode == MODE_FAST_CAP) ||
                     (mode == MODE_FAST_CMPA);
  assign dual_mode = (mode == MODE_PC8) || (mode == MODE_PC9) ||
                     (mode == MODE_PC10) || (mode == MODE_PC_CAP) ||
                     (mode == MODE_PC_CMPA);
  assign fixed_top = (mode == MODE_FAST8) || (mode == MODE_FAST9) ||
                     (mode == MODE_FAST10) || (mode == MODE_PC8) ||
                     (mode == MODE_PC9) || (mode == MODE_PC10);

  // TOP selection; compare A top uses the active copy, not the buffer
  // top value select
  always_comb begin
    case (mode)
      MODE_FAST8, MODE_PC8: top_v = TOP_8BIT;
      MODE_FAST9, MODE_PC9: top_v = TOP_9BIT;
      MODE_FAST10, MODE_PC10: top_v = TOP_10BIT;
      MODE_FAST_CAP, MODE_PC_CAP: top_v = state_q.captop;
      MODE_FAST_CMPA, MODE_PC_CMPA: top_v = state_q.act_v[0];
      default: top_v = FULL_MASK;
    endcase
  end

  // Resolution mask applied to compare writes
  // mask unused compare bits
  assign res_mask = fixed_top ? top_v : FULL_MASK;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // divider terminal count
  always_comb begin
    case (presc)
      PRESC_1: div_max = DIVM_1;
      PRESC_8: div_max = DIVM_8;
      PRESC_64: div_max = DIVM_64;
      PRESC_256: div_max = DIVM_256;
      PRESC_1024: div_max = DIVM_1024;
      default: div_max = DIVM_1;
    endcase
  end

  // Stopped or unused selects give no tick, so the counter freezes
  // tick enable
  assign tick = (presc >= PRESC_1) && (presc <= PRESC_1024) &&
                (state_q.pre == div_max);

  assign at_top = (state_q.cnt == top_v);

  // ----------------------------------------
  // Per-channel compare
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_cmp
      assign match[ch] = (state_q.cnt == state_q.act_v[ch]);
    end
  endgenerate

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Writes land on the last access edge, when pready is high
  assign wr_en = (state_q.bus == BUS_ACK) && psel && penable && pwrite;

  always_comb begin
    addr_hit = 1'b1;
    case (paddr)
      CTRL_OFS: rd_mux = {18'h0_0000, state_q.ctrl};
      COUNT_OFS: rd_mux = {16'h0000, state_q.cnt};
      CMPA_OFS: rd_mux = {16'h0000, state_q.buf_v[0]};
      CMPB_OFS: rd_mux = {16'h0000, state_q.buf_v[1]};
      CAPTOP_OFS: rd_mux = {16'h0000, state_q.captop};
      FLAGS_OFS: rd_mux = {28'h000_0000, state_q.flags};
      default: begin
        rd_mux = 32'h0000_0000;
        addr_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    fset = 4'h0;
    fclr = 4'h0;

    // Bus phase: answer one cycle after the setup cycle
    case (state_q.bus)
      BUS_IDLE: begin
        if (psel && !penable) begin
          state_d.bus = BUS_ACK;
          state_d.rdata = pwrite ? 32'h0000_0000 : rd_mux;
          state_d.slverr = !addr_hit;
        end
      end
      BUS_ACK: begin
        state_d.bus = BUS_IDLE;
        state_d.rdata = 32'h0000_0000;
        state_d.slverr = 1'b0;
      end
      default: begin
        state_d.bus = BUS_IDLE;
      end
    endcase

    // Prescaler restarts on every tick and sits at zero when stopped
    if (tick || (presc == PRESC_STOP)) begin
      state_d.pre = 10'h000;
    end else begin
      state_d.pre = 10'(state_q.pre + 10'h001);
    end

    // Outside the PWM modes the active compares follow the buffers
    if (!fast_mode && !dual_mode) begin
      state_d.act_v = state_q.buf_v;
    end

    // ----- Single-slope counting -----
    if (tick && fast_mode) begin
      if (at_top) begin
        state_d.cnt = BOTTOM;
        fset[FLG_OVF] = 1'b1;
        state_d.act_v = state_q.buf_v;
      end else begin
        state_d.cnt = 16'(state_q.cnt + 16'h0001);
      end
      if (at_top && (mode == MODE_FAST_CMPA)) begin
        fset[FLG_CMPA] = 1'b1;
      end
      if (at_top && (mode == MODE_FAST_CAP)) begin
        fset[FLG_CAP] = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
        if (match[i]) begin
          fset[FLG_CMPA + i] = 1'b1;
          if (pol[i] == POL_NONINV) begin
            state_d.wave[i] = 1'b0;
          end else if (pol[i] == POL_INV) begin
            state_d.wave[i] = 1'b1;
          end else if ((pol[i] == POL_TOGGLE) && (i == 0) &&
                       (mode == MODE_FAST_CMPA)) begin
            // toggle only with compare A top
            state_d.wave[i] = !state_q.wave[i];
          end
        end
        // Bottom action wins over a match at TOP so compare TOP is constant
        // bottom takes priority
        if (at_top) begin
          if (pol[i] == POL_NONINV) begin
            state_d.wave[i] = 1'b1;
          end else if (pol[i] == POL_INV) begin
            state_d.wave[i] = 1'b0;
          end
        end
      end
    end

    // ----- Dual-slope counting -----
    if (tick && dual_mode) begin
      if (state_q.up) begin
        if (at_top) begin
          // turn after one tick at top
          state_d.up = 1'b0;
          state_d.cnt = 16'(state_q.cnt - 16'h0001);
          state_d.act_v = state_q.buf_v;
          if (mode == MODE_PC_CMPA) begin
            fset[FLG_CMPA] = 1'b1;
          end
          if (mode == MODE_PC_CAP) begin
            fset[FLG_CAP] = 1'b1;
          end
        end else begin
          state_d.cnt = 16'(state_q.cnt + 16'h0001);
        end
      end else begin
        if (state_q.cnt == BOTTOM) begin
          fset[FLG_OVF] = 1'b1;
          state_d.up = 1'b1;
          state_d.cnt = 16'(state_q.cnt + 16'h0001);
        end else begin
          state_d.cnt = 16'(state_q.cnt - 16'h0001);
        end
      end
      // The direction after this tick decides the edge, so a match at TOP
      // sets and a match at BOTTOM clears, giving the constant extremes
      for (int i = 0; i < 2; i++) begin
        if (match[i]) begin
          fset[FLG_CMPA + i] = 1'b1;
          if (pol[i] == POL_NONINV) begin
            state_d.wave[i] = !state_d.up;
          end else if (pol[i] == POL_INV) begin
            state_d.wave[i] = state_d.up;
          end else if ((pol[i] == POL_TOGGLE) && (i == 0) &&
                       (mode == MODE_PC_CMPA)) begin
            state_d.wave[i] = !state_q.wave[i];
          end
        end
      end
    end

    // ----- Register writes -----
    if (wr_en) begin
      case (paddr)
        CTRL_OFS: begin
          state_d.ctrl = pwdata[CTRL_W-1:0];
        end
        CMPA_OFS: begin
          state_d.buf_v[0] = pwdata[15:0] & res_mask;
        end
        CMPB_OFS: begin
          state_d.buf_v[1] = pwdata[15:0] & res_mask;
        end
        CAPTOP_OFS: begin
          state_d.captop = pwdata[15:0];
        end
        FLAGS_OFS: begin
          fclr = pwdata[3:0];
        end
        default: begin
          fclr = 4'h0;
        end
      endcase
    end

    // Write one clears a flag; a hardware set in the same cycle wins
    state_d.flags = (state_q.flags & ~fclr) | fset;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // reset clears all state except up, which is set so counting starts upward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q.bus <= BUS_IDLE;
      state_q.rdata <= 32'h0000_0000;
      state_q.slverr <= 1'b0;
      state_q.ctrl <= CTRL_RST;
      state_q.cnt <= BOTTOM;
      state_q.up <= 1'b1;
      state_q.pre <= 10'h000;
      state_q.buf_v <= {CMP_RST, CMP_RST};
      state_q.act_v <= {CMP_RST, CMP_RST};
      state_q.captop <= CAPTOP_RST;
      state_q.flags <= FLAGS_RST;
      state_q.wave <= 2'h0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  assign prdata = state_q.rdata;
  assign pready = (state_q.bus == BUS_ACK);
  assign pslverr = state_q.slverr;
  assign waveform_output = state_q.wave;
  assign pin_out = state_q.wave;
  assign pin_oe = {state_q.ctrl[DIRB_BIT], state_q.ctrl[DIRA_BIT]};

endmodule

`default_nettype wire

// ---- hw/pwm_timer_pkg.sv ----
// Constants and types for the 16-bit PWM timer block
package pwm_timer_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] COUNT_OFS = 8'h04;
  localparam logic [7:0] CMPA_OFS = 8'h08;
  localparam logic [7:0] CMPB_OFS = 8'h0C;
  localparam logic [7:0] CAPTOP_OFS = 8'h10;
  localparam logic [7:0] FLAGS_OFS = 8'h14;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTRL_W = 14;
  localparam int MODE_LSB = 0;
  localparam int POLA_LSB = 4;
  localparam int POLB_LSB = 6;
  localparam int PRESC_LSB = 8;
  localparam int DIRA_BIT = 12;
  localparam int DIRB_BIT = 13;

  // ----------------------------------------
  // Flag register bits
  // ----------------------------------------
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAP = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] CAPTOP_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // ----------------------------------------
  // Count limits
  // ----------------------------------------
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] FULL_MASK = 16'hFFFF;

  // ----------------------------------------
  // Waveform mode codes
  // ----------------------------------------
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_PC_CMPA = 4'hB;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hF;

  // ----------------------------------------
  // Output polarity codes
  // ----------------------------------------
  localparam logic [1:0] POL_OFF = 2'h0;
  localparam logic [1:0] POL_TOGGLE = 2'h1;
  localparam logic [1:0] POL_NONINV = 2'h2;
  localparam logic [1:0] POL_INV = 2'h3;

  // ----------------------------------------
  // Prescaler selects and terminal counts (divide by 1, 8, 64, 256, 1024)
  // ----------------------------------------
  localparam logic [2:0] PRESC_STOP = 3'h0;
  localparam logic [2:0] PRESC_1 = 3'h1;
  localparam logic [2:0] PRESC_8 = 3'h2;
  localparam logic [2:0] PRESC_64 = 3'h3;
  localparam logic [2:0] PRESC_256 = 3'h4;
  localparam logic [2:0] PRESC_1024 = 3'h5;
  localparam logic [9:0] DIVM_1 = 10'h000;
  localparam logic [9:0] DIVM_8 = 10'h007;
  localparam logic [9:0] DIVM_64 = 10'h03F;
  localparam logic [9:0] DIVM_256 = 10'h0FF;
  localparam logic [9:0] DIVM_1024 = 10'h3FF;

  // Bus handshake phase
  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

endpackage

// ---- tb/pwm_pin_load.sv ----
// Pin load model seen by the timer output pins
`timescale 1ns/100ps
`default_nettype none
module pwm_pin_load (
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_level
);
  // undriven pin
  // Pull-up takes the pin when the timer does not drive it
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/pwm_timer16_monitor.sv ----
// Port checks for the PWM timer, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module pwm_timer16_monitor
  import pwm_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] waveform_output,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe
);
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Completed write to the control word
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pready && pwrite && (paddr == CTRL_OFS);
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
  property p_ready_cause;
    pready |-> psel && penable && $past(psel && !penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
  property p_unmapped;
    psel && penable && pready && paddr > FLAGS_OFS |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_flags_width;
    pready && !pwrite && paddr == FLAGS_OFS |-> prdata[31:4] == 28'h000_0000;
  endproperty
  a_flags_width: assert property (p_flags_width) else $error("flag word upper bits set");
  property p_oe_follows;
    ctrl_wr |=> pin_oe == $past(pwdata[13:12]);
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("pin enable misses write");
  property p_oe_cause;
    !$stable(pin_oe) |-> $past(ctrl_wr);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
  property p_reset_out;
    $rose(presetn) |-> waveform_output == 2'b00 && pin_out == 2'b00 && pin_oe == 2'b00;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not clear");
endmodule
bind pwm_timer16 pwm_timer16_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .waveform_output(waveform_output),
  .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ---- tb/tb_pwm_timer16.sv ----
// Self-checking bench for the 16-bit PWM timer
`timescale 1ns/100ps
`default_nettype none
module tb_pwm_timer16;
  import pwm_timer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] waveform_output;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] pin_level;
  logic [31:0] rdata;
  logic rerr;
  logic [31:0] ha;
  logic [31:0] hb;
  int miscompares = 0;
  int tests_run = 0;
  logic [3:0] mt [7] = '{MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_PC8, MODE_PC9,
    MODE_PC10, MODE_FAST_CAP};
  logic [15:0] mk [7] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT, TOP_8BIT, TOP_9BIT,
    TOP_10BIT, FULL_MASK};
  logic [9:0] dv [5] = '{DIVM_1, DIVM_8, DIVM_64, DIVM_256, DIVM_1024};

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  pwm_timer16 i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .waveform_output(waveform_output), .pin_out(pin_out),
    .pin_oe(pin_oe));
  pwm_pin_load i_load (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so no signal is driven twice in one step
    @(posedge pclk);
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    check(name, rdata, e);
  endtask

  task automatic reset_dut();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  function automatic logic [13:0] cw(input logic [3:0] m, input logic [1:0] pa,
    input logic [1:0] pb, input logic [2:0] ps);
    return {2'b11, 1'b0, ps, pb, pa, m};
  endfunction

  // Fresh start, program, then count high cycles over a window of win cycles
  task automatic run(input logic [13:0] c, input logic [15:0] top, input logic [15:0] ca,
    input logic [15:0] cb, input int win, input logic [31:0] ea, input logic [31:0] eb);
    reset_dut();
    xfer(1'b1, CAPTOP_OFS, {16'h0000, top});
    xfer(1'b1, CMPA_OFS, {16'h0000, ca});
    xfer(1'b1, CMPB_OFS, {16'h0000, cb});
    xfer(1'b1, CTRL_OFS, {18'h0_0000, c});
    repeat (win + 40) @(posedge pclk);
    ha = 32'h0000_0000;
    hb = 32'h0000_0000;
    repeat (win) begin
      @(posedge pclk);
      ha = ha + {31'h0, waveform_output[0] === 1'b1};
      hb = hb + {31'h0, waveform_output[1] === 1'b1};
    end
    check("high time a", ha, ea);
    check("high time b", hb, eb);
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    reset_dut();
    for (int i = 0; i < 6; i++) begin
      rchk("reset value", 8'(4 * i), 32'h0000_0000);
    end
    xfer(1'b0, 8'h18, 32'h0000_0000);
    check("unmapped read", {rdata[30:0], rerr}, 32'h0000_0001);
    xfer(1'b1, 8'h18, 32'h0000_FFFF);
    check("unmapped write", {31'h0, rerr}, 32'h0000_0001);
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, CTRL_OFS, {28'h0, mt[i]});
      xfer(1'b1, CMPB_OFS, 32'h0000_FFFF);
      rchk("masked compare", CMPB_OFS, {16'h0, mk[i]});
    end
    // Single-slope shapes, extremes included; register tops kept legal
    run(cw(MODE_FAST8, POL_NONINV, POL_INV, PRESC_1),
      16'h0, 16'h0080, 16'h0, 256, 129, 255);
    run(cw(MODE_FAST8, POL_NONINV, POL_NONINV, PRESC_1),
      16'h0, 16'h00FF, 16'h0, 256, 256, 1);
    run(cw(MODE_FAST9, POL_NONINV, POL_INV, PRESC_1),
      16'h0, 16'h0100, 16'h01FF, 512, 257, 0);
    run(cw(MODE_FAST10, POL_NONINV, POL_INV, PRESC_1), 16'h0, 16'h03FF, 16'h0200, 1024, 1024,
      511);
    run(cw(MODE_FAST_CAP, POL_NONINV, POL_INV, PRESC_1),
      16'h0009, 16'h3, 16'h5, 10, 4, 4);
    xfer(1'b1, FLAGS_OFS, 32'h0000_000F);
    repeat (20) @(posedge pclk);
    rchk("fast flags", FLAGS_OFS, 32'h0000_000F);
    for (int i = 0; i < 5; i++) begin
      run(cw(MODE_FAST_CMPA, POL_TOGGLE, POL_NONINV, 3'(i + 1)), 16'h0, 16'h7, 16'h2,
        16 * (dv[i] + 1), 8 * (dv[i] + 1), 6 * (dv[i] + 1));
    end
    // Dual-slope shapes
    run(cw(MODE_PC8, POL_NONINV, POL_INV, PRESC_1),
      16'h0, 16'h0040, 16'h0, 510, 128, 510);
    run(cw(MODE_PC9, POL_NONINV, POL_NONINV, PRESC_1),
      16'h0, 16'h01FF, 16'h0, 1022, 1022, 0);
    run(cw(MODE_PC_CAP, POL_NONINV, POL_NONINV, PRESC_1),
      16'h20, 16'h8, 16'h20, 64, 16, 64);
    xfer(1'b1, FLAGS_OFS, 32'h0000_000F);
    repeat (80) @(posedge pclk);
    rchk("dual flags", FLAGS_OFS, 32'h0000_000F);
    run(cw(MODE_PC_CMPA, POL_TOGGLE, POL_INV, PRESC_1),
      16'h0, 16'h0010, 16'h8, 64, 32, 32);
    check("pin level", {30'h0, pin_level}, {30'h0, waveform_output});
    xfer(1'b1, CTRL_OFS, {18'h0, cw(MODE_PC_CMPA, POL_TOGGLE, POL_INV, PRESC_1) & 14'h0FFF});
    check("released pins", {28'h0, pin_oe, pin_level}, 32'h0000_0003);
    // Stopped prescaler freezes the count wherever the dual slope left it
    xfer(1'b1, CTRL_OFS, {18'h0, cw(MODE_FAST_CMPA, POL_TOGGLE, POL_OFF, PRESC_STOP)});
    xfer(1'b0, COUNT_OFS, 32'h0000_0000);
    ha = rdata;
    check("count", {31'h0, ha[15:0] <= 16'h0010}, 32'h0000_0001);
    repeat (50) @(posedge pclk);
    rchk("frozen count", COUNT_OFS, ha);
    // Top written below the running count is missed
    run(cw(MODE_FAST_CAP, POL_OFF, POL_OFF, PRESC_1), 16'h1000, 16'h0, 16'h0, 16, 0, 0);
    xfer(1'b1, CAPTOP_OFS, 32'h0000_0003);
    repeat (20) @(posedge pclk);
    xfer(1'b0, COUNT_OFS, 32'h0000_0000);
    check("missed top", {31'h0, rdata[15:0] > 16'h0010}, 32'h0000_0001);
    print_verdict();
  end
endmodule
`default_nettype wire
